// ==== hw/iso_rx_ctx_defines.vh ====
/*
 Constants for the isochronous receive context control block: register
 offsets, field positions, speed and event codes, reset values.
 Assumes inclusion by bare name from design files.
*/
`ifndef ISO_RX_CTX_DEFINES_VH
`define ISO_RX_CTX_DEFINES_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define CTL_SET_ADDR 8'h00
`define CTL_CLR_ADDR 8'h04
`define CTL_READ_ADDR 8'h08
`define CHAN_ADDR 8'h0C
`define MASK_HI_ADDR 8'h10
`define MASK_LO_ADDR 8'h14
`define PKT_CHAN_ADDR 8'h18

// ****************************************
// Control field positions
// ****************************************
`define B_PACKED 31
`define B_HDR 30
`define B_CYCM 29
`define B_MULTI 28
`define B_SPLIT 27
`define B_RUN 15
`define B_WAKE 12
`define B_DEAD 11
`define B_ACTIVE 10
`define SPD_HI 7
`define SPD_LO 5
`define EVT_HI 4
`define EVT_LO 0

// ****************************************
// Speed codes
// ****************************************
`define SPD_100 3'h0
`define SPD_200 3'h1
`define SPD_400 3'h2

// ****************************************
// Event codes
// ****************************************
`define EVT_NONE 5'h00
`define EVT_LONG_PACKET 5'h02
`define EVT_DESC_READ 5'h04
`define EVT_DATA_WRITE 5'h06
`define EVT_OVERRUN 5'h05
`define EVT_UNKNOWN 5'h0E
`define ACK_COMPLETE 5'h11
`define ACK_DATA_ERROR 5'h1D

// ****************************************
// Misc
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ZERO32 32'h00000000
`define ONE2 2'h1

`endif

// ==== hw/iso_rx_context_control.v ====
/*
 Control and status of one isochronous receive DMA context, reached over
 AXI4-Lite. Holds the set/clear control register, the channel filter and
 the descriptor run/wake/dead/active handshake. Assumes a DMA engine on
 the same clock that reports fetches, errors and received packets.
*/
// Added by the designer: the AXI4-Lite slave port and the address map.
// Function
// - Multi-channel: accept all mask-enabled channels
// - Otherwise accept only the programmed channel
// - Split mode sends payloads to two series
// - Split mode forces multi and packed low
// - Split bit frozen while active or run
// - Reserved bits read zero
// - Descriptors processed only while run set
// - Hardware changes run only on reset
// - Wake makes descriptor fetching resume
// - Every descriptor fetch clears wake
// - Fatal error sets dead (code sets it only while run is set)
// - Dead clears only when software clears run
// - Active high while processing descriptors
// - Speed field codes 100, 200, 400
// - Packed-fill event codes limited set
// - Packed-fill backs out bad packets
// - Packet-per-buffer event codes limited set
// - Packed fills buffers; otherwise one per buffer
`include "iso_rx_ctx_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module iso_rx_context_control #(
   parameter CHAN_W = 6
)(
   input wire aclk,
   input wire aresetn,
   input wire sw_reset,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire desc_fetch,
   input wire fatal_error,
   input wire proc_idle,
   input wire pkt_valid,
   input wire [CHAN_W-1:0] pkt_channel,
   input wire [2:0] pkt_speed,
   input wire pkt_len_err,
   input wire pkt_crc_err,
   input wire pkt_overrun,
   input wire pkt_long,
   input wire desc_read_err,
   input wire data_write_err,
   output reg fetch_enable,
   output reg pkt_accept,
   output reg pkt_backout,
   output reg packed_fill_select,
   output reg split_payload_select,
   output reg multi_channel_select,
   output reg header_keep
);

   // ****************************************
   // Control state
   // ****************************************
   reg run_q;
   reg wake_q;
   reg dead_q;
   reg active_q;
   reg cycm_q;
   reg [2:0] spd_q;
   reg [4:0] evt_q;
   reg [CHAN_W-1:0] chan_q;
   reg [31:0] mask_hi_q;
   reg [31:0] mask_lo_q;
   reg [CHAN_W-1:0] last_chan_q;

   reg [7:0] awaddr_q;
   reg aw_have_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg w_have_q;

   wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
   wire set_wr = do_write && awaddr_q == `CTL_SET_ADDR;
   wire clr_wr = do_write && awaddr_q == `CTL_CLR_ADDR;
   wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
      {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire [31:0] set_bits = set_wr ? (wdata_q & wmask) : `ZERO32;
   wire [31:0] clr_bits = clr_wr ? (wdata_q & wmask) : `ZERO32;
   wire busy = active_q || run_q;

   // Mask bit selection, used by filter
   function chan_enabled;
      input [CHAN_W-1:0] ch;
      input [31:0] hi;
      input [31:0] lo;
      begin
         if (ch[5])
            chan_enabled = hi[ch[4:0]];
         else
            chan_enabled = lo[ch[4:0]];
      end
   endfunction

   // Merge set/clear writes onto a bit
   function sc;
      input cur;
      input s;
      input c;
      begin
         sc = (cur | s) & ~c;
      end
   endfunction

   // ****************************************
   // Control register update
   // ****************************************
   reg split_d;
   reg multi_d;
   reg packed_d;
   always @*
   begin
      split_d = busy ? split_payload_select :
         sc(split_payload_select, set_bits[`B_SPLIT], clr_bits[`B_SPLIT]);
      multi_d = sc(multi_channel_select, set_bits[`B_MULTI],
         clr_bits[`B_MULTI]);
      packed_d = sc(packed_fill_select, set_bits[`B_PACKED],
         clr_bits[`B_PACKED]);
      if (split_d)
      begin
         multi_d = 1'b0;
         packed_d = 1'b0;
      end
   end

   wire pkt_ok = pkt_valid && active_q;
   wire pkt_bad = pkt_len_err || pkt_crc_err || pkt_overrun;
   wire accept_now = multi_channel_select ?
      chan_enabled(pkt_channel, mask_hi_q, mask_lo_q) :
      (pkt_channel == chan_q);

   reg [4:0] evt_d;
   always @*
   begin
      evt_d = `ACK_COMPLETE;
      if (desc_read_err)
         evt_d = `EVT_DESC_READ;
      else if (data_write_err)
         evt_d = `EVT_DATA_WRITE;
      else if (packed_fill_select)
      begin
         if (pkt_bad)
            evt_d = evt_q;
      end
      else if (pkt_overrun)
         evt_d = `EVT_OVERRUN;
      else if (pkt_long)
         evt_d = `EVT_LONG_PACKET;
      else if (pkt_len_err || pkt_crc_err)
         evt_d = `ACK_DATA_ERROR;
   end

   always @(posedge aclk)
   begin
      if (!aresetn || sw_reset)
      begin
         run_q <= 1'b0;
         wake_q <= 1'b0;
         dead_q <= 1'b0;
         active_q <= 1'b0;
         cycm_q <= 1'b0;
         header_keep <= 1'b0;
         split_payload_select <= 1'b0;
         multi_channel_select <= 1'b0;
         packed_fill_select <= 1'b0;
         spd_q <= `SPD_100;
         evt_q <= `EVT_NONE;
         fetch_enable <= 1'b0;
         pkt_accept <= 1'b0;
         pkt_backout <= 1'b0;
         last_chan_q <= {CHAN_W{1'b0}};
      end
      else
      begin
         run_q <= sc(run_q, set_bits[`B_RUN], clr_bits[`B_RUN]);
         header_keep <= sc(header_keep, set_bits[`B_HDR], clr_bits[`B_HDR]);
         cycm_q <= active_q ? 1'b0 :
            sc(cycm_q, set_bits[`B_CYCM], clr_bits[`B_CYCM]);
         split_payload_select <= split_d;
         multi_channel_select <= multi_d;
         packed_fill_select <= packed_d;
         // Fetch beats a same-cycle wake set
         if (desc_fetch)
            wake_q <= 1'b0;
         else if (set_bits[`B_WAKE])
            wake_q <= 1'b1;
         if (fatal_error && run_q)
            dead_q <= 1'b1;
         else if (clr_bits[`B_RUN])
            dead_q <= 1'b0;
         // Active while run, not halted and the engine busy; a wake restarts an idle engine
         if (!run_q || dead_q || fatal_error)
            active_q <= 1'b0;
         else if (set_bits[`B_WAKE] || wake_q || !proc_idle)
            active_q <= 1'b1;
         else
            active_q <= 1'b0;
         fetch_enable <= run_q && !dead_q && !fatal_error &&
            !clr_bits[`B_RUN];
         pkt_accept <= pkt_ok && accept_now && !(packed_fill_select
            && pkt_bad);
         pkt_backout <= pkt_ok && accept_now && packed_fill_select
            && pkt_bad;
         if (pkt_ok && accept_now)
         begin
            spd_q <= pkt_speed;
            evt_q <= evt_d;
            last_chan_q <= pkt_channel;
         end
         else if (desc_read_err || data_write_err)
            evt_q <= evt_d;
      end
   end

   // ****************************************
   // Plain registers
   // ****************************************
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         chan_q <= {CHAN_W{1'b0}};
         mask_hi_q <= `ZERO32;
         mask_lo_q <= `ZERO32;
      end
      else if (do_write)
      begin
         if (awaddr_q == `CHAN_ADDR)
            chan_q <= wdata_q[CHAN_W-1:0];
         if (awaddr_q == `MASK_HI_ADDR)
            mask_hi_q <= (mask_hi_q & ~wmask) | (wdata_q & wmask);
         if (awaddr_q == `MASK_LO_ADDR)
            mask_lo_q <= (mask_lo_q & ~wmask) | (wdata_q & wmask);
      end
   end

   // ****************************************
   // AXI4-Lite write channel
   // ****************************************
   wire known_w = awaddr_q == `CTL_SET_ADDR || awaddr_q == `CTL_CLR_ADDR
      || awaddr_q == `CHAN_ADDR || awaddr_q == `MASK_HI_ADDR
      || awaddr_q == `MASK_LO_ADDR;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= `ZERO32;
         wstrb_q <= 4'h0;
      end
      else
      begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known_w ? `RESP_OKAY : `RESP_SLVERR;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   wire [31:0] ctl_word = {packed_fill_select, header_keep, cycm_q,
      multi_channel_select, split_payload_select, 11'h000, run_q, 2'h0,
      wake_q, dead_q, active_q, 2'h0, spd_q, evt_q};

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `ZERO32;
         s_axi_rresp <= `RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (s_axi_araddr)
               `CTL_SET_ADDR, `CTL_CLR_ADDR, `CTL_READ_ADDR:
                  s_axi_rdata <= ctl_word;
               `CHAN_ADDR:
                  s_axi_rdata <= {{(32-CHAN_W){1'b0}}, chan_q};
               `MASK_HI_ADDR:
                  s_axi_rdata <= mask_hi_q;
               `MASK_LO_ADDR:
                  s_axi_rdata <= mask_lo_q;
               `PKT_CHAN_ADDR:
                  s_axi_rdata <= {{(32-CHAN_W){1'b0}}, last_chan_q};
               default:
               begin
                  s_axi_rdata <= `ZERO32;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule // iso_rx_context_control

`default_nettype wire

// ==== test/iso_rx_ctx_props.sv ====
/*
 Checker for the receive context control ports.
 Assumes a bind onto the design top; one clock, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iso_rx_ctx_defines.vh"
module iso_rx_ctx_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sw_reset,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic fatal_error,
   input wire logic pkt_valid,
   input wire logic pkt_len_err,
   input wire logic pkt_crc_err,
   input wire logic pkt_overrun,
   input wire logic fetch_enable,
   input wire logic pkt_accept,
   input wire logic pkt_backout,
   input wire logic packed_fill_select,
   input wire logic split_payload_select,
   input wire logic multi_channel_select
);
   logic [7:0] rd_addr_q;
   wire logic ctl_rd;
   wire logic bad_in;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always @(posedge aclk)
      if (s_axi_arvalid && s_axi_arready)
         rd_addr_q <= s_axi_araddr;
   assign ctl_rd = s_axi_rvalid && rd_addr_q <= `CTL_READ_ADDR;
   assign bad_in = pkt_valid && packed_fill_select
      && (pkt_len_err || pkt_crc_err || pkt_overrun);
   sequence halt_seq;
      ##[1:2] !fetch_enable;
   endsequence
   sequence bad_pkt;
      bad_in;
   endsequence
   chk_split_clears_modes:
      assert property (split_payload_select |-> !multi_channel_select
         && !packed_fill_select) else $error("split left modes set");
   chk_split_frozen:
      assert property (fetch_enable && !sw_reset |=>
         $stable(split_payload_select)) else $error("split moved in run");
   chk_fatal_halts:
      assert property (fatal_error && fetch_enable && !sw_reset |->
         halt_seq) else $error("fatal error did not halt");
   chk_halted_no_accept:
      assert property ((!fetch_enable [*4]) ##0 pkt_valid |=> !pkt_accept)
         else $error("packet taken while stopped");
   chk_accept_cause:
      assert property (pkt_accept |-> $past(pkt_valid) && !pkt_backout)
         else $error("accept without packet");
   chk_backout_cause:
      assert property (pkt_backout |-> $past(bad_in))
         else $error("backout without bad packet");
   chk_bad_not_taken:
      assert property (bad_pkt |=> !pkt_accept)
         else $error("bad packet kept in packed mode");
   chk_reserved_zero:
      assert property (ctl_rd |-> s_axi_rdata[26:16] == 11'h000
         && s_axi_rdata[14:13] == 2'h0 && s_axi_rdata[9:8] == 2'h0)
         else $error("reserved bits not zero");
   chk_event_packed:
      assert property (ctl_rd && s_axi_rdata[31] |-> s_axi_rdata[4:0]
         inside {`ACK_COMPLETE, `EVT_DESC_READ, `EVT_DATA_WRITE,
         `EVT_UNKNOWN, `EVT_NONE}) else $error("bad packed event");
   chk_event_single:
      assert property (ctl_rd && !s_axi_rdata[31] |-> s_axi_rdata[4:0]
         inside {`ACK_COMPLETE, `ACK_DATA_ERROR, `EVT_LONG_PACKET,
         `EVT_OVERRUN, `EVT_DESC_READ, `EVT_DATA_WRITE, `EVT_UNKNOWN,
         `EVT_NONE}) else $error("bad per-buffer event");
endmodule // iso_rx_ctx_props
bind iso_rx_context_control iso_rx_ctx_props chk_u (.aclk, .aresetn,
   .sw_reset, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .fatal_error, .pkt_valid, .pkt_len_err, .pkt_crc_err,
   .pkt_overrun, .fetch_enable, .pkt_accept, .pkt_backout,
   .packed_fill_select, .split_payload_select, .multi_channel_select);
`default_nettype wire

// ==== test/dma_engine_model.sv ====
/*
 Behavioural DMA engine facing the context control block.
 Assumes its tasks are called in the time step of a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module dma_engine_model (
   input wire logic aclk,
   input wire logic fetch_enable,
   output logic desc_fetch,
   output logic fatal_error,
   output logic proc_idle,
   output logic pkt_valid,
   output logic [5:0] pkt_channel,
   output logic [2:0] pkt_speed,
   output logic [3:0] pkt_err,
   output logic desc_read_err,
   output logic data_write_err
);
   int pend = 0;
   initial {fatal_error, desc_read_err, data_write_err} = 3'h0;
   initial {pkt_valid, pkt_channel, pkt_speed, pkt_err} = 14'h0000;
   assign proc_idle = pend == 0;
   // Fetch only while enabled
   always @(posedge aclk)
   begin
      desc_fetch <= fetch_enable && pend > 0;
      if (fetch_enable && pend > 0)
         pend <= pend - 1;
   end
   task automatic give(input int n);
      @(posedge aclk);
      pend <= n;
   endtask
   // Status lines show inverted junk once released
   task automatic pkt(input logic [5:0] ch, input logic [2:0] sp,
      input logic [3:0] er);
      @(posedge aclk);
      {pkt_valid, pkt_channel, pkt_speed, pkt_err} <= {1'b1, ch, sp, er};
      @(posedge aclk);
      {pkt_valid, pkt_channel, pkt_speed, pkt_err} <= {1'b0, ~ch, ~sp, ~er};
   endtask
   task automatic pulse(input int k);
      @(posedge aclk);
      {fatal_error, desc_read_err, data_write_err} <= 3'h4 >> k;
      @(posedge aclk);
      {fatal_error, desc_read_err, data_write_err} <= 3'h0;
   endtask
endmodule // dma_engine_model
`default_nettype wire

// ==== test/iso_rx_context_control_tb_top.sv ====
/*
 Self-checking bench for the receive context control block.
 Assumes the design, its defines header and the engine model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iso_rx_ctx_defines.vh"
module iso_rx_context_control_tb_top;
   logic aclk, aresetn, sw_reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, desc_fetch, fatal_error;
   logic proc_idle, pkt_valid, desc_read_err, data_write_err, fetch_enable;
   logic pkt_accept, pkt_backout, packed_fill_select, split_payload_select;
   logic multi_channel_select, header_keep;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb, pkt_err;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [5:0] pkt_channel;
   logic [2:0] pkt_speed;
   int failures = 0, checked = 0, cycles = 0;
   iso_rx_context_control dut_u (.aclk, .aresetn, .sw_reset, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .desc_fetch,
      .fatal_error, .proc_idle, .pkt_valid, .pkt_channel, .pkt_speed,
      .pkt_len_err(pkt_err[0]), .pkt_crc_err(pkt_err[1]),
      .pkt_overrun(pkt_err[2]), .pkt_long(pkt_err[3]), .desc_read_err,
      .data_write_err, .fetch_enable, .pkt_accept, .pkt_backout,
      .packed_fill_select, .split_payload_select, .multi_channel_select,
      .header_keep);
   dma_engine_model eng_u (.aclk, .fetch_enable, .desc_fetch, .fatal_error,
      .proc_idle, .pkt_valid, .pkt_channel, .pkt_speed, .pkt_err,
      .desc_read_err, .data_write_err);
   // ****************************************
   // Bus and compare tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      rr = s_axi_bresp;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
   endtask
   task automatic ctl(input logic [31:0] m, input logic [31:0] exp);
      rd(`CTL_READ_ADDR);
      chk(v & m, exp);
   endtask
   task automatic acc(input logic [5:0] c, input logic [2:0] s,
      input logic [3:0] e, input logic [1:0] exp);
      eng_u.pkt(c, s, e);
      #1;
      chk({pkt_accept, pkt_backout}, exp);
      @(posedge aclk);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_modes;
      ctl(32'hFFFFFFFF, 32'h0);
      wr(`CTL_SET_ADDR, 32'h98000000);
      ctl(32'h98000000, 32'h08000000);
      chk({packed_fill_select, multi_channel_select, split_payload_select}, 1);
      wr(`CTL_SET_ADDR, 32'h8000);
      wr(`CTL_CLR_ADDR, 32'h08000000);
      ctl(32'h08008000, 32'h08008000);
      wr(`CTL_CLR_ADDR, 32'h8000);
      wr(`CTL_CLR_ADDR, 32'h08000000);
      ctl(32'h08000000, 0);
      $display("modes done");
   endtask
   task automatic t_filter;
      wr(`CHAN_ADDR, 32'h5);
      wr(`CTL_SET_ADDR, 32'h9000);
      for (int i = 0; i < 3; i++)
      begin
         acc(6'h05, i[2:0], 4'h0, 2'h2);
         ctl(32'hFF, {i[2:0], `ACK_COMPLETE});
         acc(6'h05, 3'h0, 4'h8 >> i, 2'h2);
         ctl(32'h1F, i == 0 ? `EVT_LONG_PACKET : i == 1 ? `EVT_OVERRUN
            : `ACK_DATA_ERROR);
      end
      acc(6'h06, 3'h0, 4'h0, 2'h0);
      wr(`CTL_CLR_ADDR, 32'h8000);
      acc(6'h05, 3'h0, 4'h0, 2'h0);
      wr(`MASK_LO_ADDR, 32'h40);
      wr(`CTL_SET_ADDR, 32'h90009000);
      acc(6'h06, 3'h1, 4'h0, 2'h2);
      acc(6'h05, 3'h1, 4'h0, 2'h0);
      for (int i = 0; i < 3; i++)
         acc(6'h06, 3'h0, 4'h1 << i, 2'h1);
      ctl(32'h1F, `ACK_COMPLETE);
      wr(`CTL_CLR_ADDR, 32'h8000);
      wr(`CTL_CLR_ADDR, 32'hFFFFFFFF);
      $display("filter done");
   endtask
   task automatic t_wake;
      wr(`CTL_SET_ADDR, 32'h9000);
      ctl(32'h1400, 32'h1400);
      eng_u.give(2);
      @(posedge aclk);
      while (!proc_idle)
         @(posedge aclk);
      repeat (3) @(posedge aclk);
      ctl(32'h1400, 0);
      wr(`CTL_CLR_ADDR, 32'h8000);
      eng_u.give(1);
      repeat (4) @(posedge aclk);
      chk(proc_idle, 0);
      wr(`CTL_SET_ADDR, 32'h8000);
      while (!proc_idle)
         @(posedge aclk);
      $display("wake done");
   endtask
   task automatic t_fatal;
      eng_u.pulse(0);
      repeat (2) @(posedge aclk);
      ctl(32'h8C00, 32'h8800);
      chk(fetch_enable, 0);
      wr(`CTL_SET_ADDR, 32'h8000);
      ctl(32'h0800, 32'h0800);
      wr(`CTL_CLR_ADDR, 32'h8000);
      ctl(32'h8800, 0);
      eng_u.pulse(1);
      ctl(32'h1F, `EVT_DESC_READ);
      eng_u.pulse(2);
      ctl(32'h1F, `EVT_DATA_WRITE);
      wr(`CTL_SET_ADDR, 32'h40008000);
      chk(header_keep, 1);
      sw_reset <= 1'b1;
      @(posedge aclk);
      sw_reset <= 1'b0;
      ctl(32'hFFFFFFFF, 0);
      chk(header_keep, 0);
      rd(8'h40);
      chk(rr, `RESP_SLVERR);
      chk(v, 32'h0);
      wr(8'h40, 32'hFFFFFFFF);
      chk(rr, `RESP_SLVERR);
      $display("fatal done");
   endtask
   task end_of_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      aclk = 0;
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         end_of_test;
      end
   end
   initial
   begin
      {aresetn, sw_reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_modes;
      t_filter;
      t_wake;
      t_fatal;
      end_of_test;
   end
endmodule // iso_rx_context_control_tb_top
`default_nettype wire
